// ===== src/obf_filter.sv
// Overhead bit change filter with AHB-Lite register access.
`timescale 1ns/100ps
`include "obf_consts.svh"

module obf_filter
	import obf_pkg::*;
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// AHB-Lite slave.
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// Received superframe bits.
	input wire logic i_sf_valid,
	input wire logic [7:0] i_sf_grp1,
	input wire logic [2:0] i_sf_grp2,
	input wire logic i_sf_crc_ok,
	// Operating mode, receiver state and test state entry.
	input wire obf_mode_e i_mode,
	input wire logic [3:0] i_rx_state,
	input wire logic i_test_entry,
	// Local command message.
	input wire logic i_lcmd_valid,
	input wire logic i_lcmd_reg,
	input wire logic [7:0] i_lcmd_code,
	// Overhead report messages.
	output logic o_rpt1_valid,
	output logic [7:0] o_rpt1_bits,
	output logic o_rpt2_valid,
	output logic [2:0] o_rpt2_bits,
	output logic o_rpt_up
);
	logic ctrl_en_ff;
	logic dflt_load_ff;
	logic crc_h1_ff, crc_h2_ff;
	logic [15:0] count_ff;
	logic [3:0] wr_ofs_ff;
	logic wr_pend_ff;
	logic allowed;
	logic crc2;
	logic cmd_ok;
	logic bus_go;
	logic [7:0] grp_in [2];
	logic [7:0] ref_w [2];
	logic [1:0] meth_w [2];
	logic [1:0] evt_w;
	logic [1:0] tm_w;
	logic [31:0] nxt_rdata;

	assign grp_in[0] = i_sf_grp1;
	assign grp_in[1] = {5'h00, i_sf_grp2};
	assign crc2 = crc_h1_ff & crc_h2_ff;
	assign cmd_ok = i_lcmd_valid && !i_lcmd_reg && i_lcmd_code[7:3] == `OBF_CMD_PREFIX;
	assign bus_go = i_hsel && i_htrans[1] && i_hready;

	// Synchronized states per operating mode.
	always_comb begin
		allowed = 1'b0;
		unique case (i_mode)
			OBF_LT: begin
				allowed = i_rx_state inside {`OBF_ST_LINE_ACTIVE, `OBF_ST_PEND_TRANSP,
					`OBF_ST_ST_DEACT, `OBF_ST_PEND_DEACT, `OBF_ST_TRANSP};
			end
			OBF_NT: begin
				allowed = i_rx_state inside {`OBF_ST_SYNC1, `OBF_ST_SYNC2, `OBF_ST_WAIT_ACT,
					`OBF_ST_TRANSP, `OBF_ST_ERROR, `OBF_ST_PEND_DEACT_ST,
					`OBF_ST_PEND_DEACT_U, `OBF_ST_ALOOP};
			end
			OBF_LT_RELAY: begin
				allowed = i_rx_state inside {`OBF_ST_PEND_TRANSP, `OBF_ST_TRANSP,
					`OBF_ST_PEND_DEACT};
			end
			OBF_NT_RELAY: begin
				allowed = i_rx_state inside {`OBF_ST_SYNC1, `OBF_ST_TRANSP, `OBF_ST_ERROR,
					`OBF_ST_PEND_DEACT, `OBF_ST_ALOOP};
			end
		endcase
	end

	// Defaults are loaded after reset release and on every test state entry.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dflt_load_ff <= 1'b1;
		end else begin
			dflt_load_ff <= i_test_entry;
		end
	end

	// CRC results of the two completed superframes before the current one.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crc_h1_ff <= 1'b0;
			crc_h2_ff <= 1'b0;
		end else if (i_sf_valid) begin
			crc_h1_ff <= i_sf_crc_ok;
			crc_h2_ff <= crc_h1_ff;
		end
	end

	generate
		for (genvar g = 0; g < 2; g++) begin : g_grp
			logic [7:0] h1_ff, h2_ff, ref_ff;
			logic [1:0] meth_ff;
			logic tm_ok, qual, sel;
			// Group one codes have bit 2 set, group two codes have it clear.
			assign sel = i_lcmd_code[`OBF_CMD_GRP_BIT] == (g == 0);
			assign tm_ok = grp_in[g] == h1_ff && h1_ff == h2_ff;
			always_comb begin
				qual = 1'b1;
				if (meth_ff[1]) begin
					qual = qual & tm_ok;
				end
				if (meth_ff[0]) begin
					qual = qual & crc2;
				end
			end
			// On-change needs no qualifier beyond the polarity difference.
			assign evt_w[g] = i_sf_valid && allowed && ctrl_en_ff &&
				grp_in[g] != ref_ff && qual;
			always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meth_ff <= OBF_TRIPLE;
				end else if (dflt_load_ff) begin
					meth_ff <= (i_mode inside {OBF_LT_RELAY, OBF_NT_RELAY}) ?
						OBF_CRC : OBF_TRIPLE;
				end else if (cmd_ok && sel) begin
					meth_ff <= i_lcmd_code[1:0];
				end
			end
			always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					h1_ff <= 8'h00;
					h2_ff <= 8'h00;
				end else if (i_sf_valid) begin
					h1_ff <= grp_in[g];
					h2_ff <= h1_ff;
				end
			end
			always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					ref_ff <= 8'h00;
				end else if (evt_w[g]) begin
					ref_ff <= grp_in[g];
				end
			end
			assign meth_w[g] = meth_ff;
			assign ref_w[g] = ref_ff;
			assign tm_w[g] = tm_ok;
		end
	endgenerate

	// Report message outputs.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rpt1_valid <= 1'b0;
			o_rpt1_bits <= 8'h00;
			o_rpt2_valid <= 1'b0;
			o_rpt2_bits <= 3'h0;
		end else begin
			o_rpt1_valid <= evt_w[0];
			o_rpt2_valid <= evt_w[1];
			if (evt_w[0]) begin
				o_rpt1_bits <= i_sf_grp1;
			end
			if (evt_w[1]) begin
				o_rpt2_bits <= i_sf_grp2;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rpt_up <= 1'b0;
		end else begin
			o_rpt_up <= i_mode inside {OBF_LT, OBF_LT_RELAY};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_ff <= 16'h0000;
		end else if (wr_pend_ff && wr_ofs_ff == `OBF_OFS_COUNT) begin
			count_ff <= 16'h0000;
		end else begin
			count_ff <= count_ff + 16'(evt_w[0]) + 16'(evt_w[1]);
		end
	end

	// Bus slave: zero wait states, writes land in the data phase.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_pend_ff <= 1'b0;
			wr_ofs_ff <= 4'h0;
		end else begin
			wr_pend_ff <= bus_go && i_hwrite && i_haddr[31:4] == 28'h0000000;
			wr_ofs_ff <= i_haddr[3:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_en_ff <= `OBF_CTRL_RST;
		end else if (wr_pend_ff && wr_ofs_ff == `OBF_OFS_CTRL) begin
			ctrl_en_ff <= i_hwdata[0];
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (i_haddr[31:4] == 28'h0000000) begin
			unique case (i_haddr[3:0])
				`OBF_OFS_CTRL: nxt_rdata = {31'h0, ctrl_en_ff};
				`OBF_OFS_STATUS: nxt_rdata = {27'h0, allowed, meth_w[1], meth_w[0]};
				`OBF_OFS_REF: nxt_rdata = {21'h0, ref_w[1][2:0], ref_w[0]};
				`OBF_OFS_COUNT: nxt_rdata = {16'h0, count_ff};
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hrdata <= 32'h0000_0000;
			o_hreadyout <= 1'b0;
			o_hresp <= 1'b0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			if (bus_go && !i_hwrite) begin
				o_hrdata <= nxt_rdata;
			end
		end
	end

	sequence s_cmd1;
		cmd_ok && i_lcmd_code[2] && !dflt_load_ff;
	endsequence
	sequence s_cmd2;
		cmd_ok && !i_lcmd_code[2] && !dflt_load_ff;
	endsequence

	property p_cmd1;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_cmd1 |=> meth_w[0] == $past(i_lcmd_code[1:0]);
	endproperty
	a_cmd1: assert property (p_cmd1) else $error("group one method not taken");

	property p_cmd2;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_cmd2 |=> meth_w[1] == $past(i_lcmd_code[1:0]);
	endproperty
	a_cmd2: assert property (p_cmd2) else $error("group two method not taken");

	property p_regsel;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_lcmd_valid && i_lcmd_reg && !dflt_load_ff |=> $stable(meth_w[0]) && $stable(meth_w[1]);
	endproperty
	a_regsel: assert property (p_regsel) else $error("register command changed method");

	property p_dflt;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_test_entry ##1 !(i_mode inside {OBF_LT_RELAY, OBF_NT_RELAY})
			|=> meth_w[0] == OBF_TRIPLE && meth_w[1] == OBF_TRIPLE;
	endproperty
	a_dflt: assert property (p_dflt) else $error("default method not restored");

	property p_sync;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_rpt1_valid || o_rpt2_valid |-> $past(allowed) && $past(i_sf_valid);
	endproperty
	a_sync: assert property (p_sync) else $error("report while unsynchronized");

	property p_triple;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_rpt1_valid && $past(meth_w[0][1]) |-> $past(tm_w[0]);
	endproperty
	a_triple: assert property (p_triple) else $error("report without triple match");

	property p_crc;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_rpt2_valid && $past(meth_w[1][0]) |-> $past(crc_h1_ff) && $past(crc_h2_ff, 1);
	endproperty
	a_crc: assert property (p_crc) else $error("report without good CRC history");

	property p_ref;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_rpt1_valid |-> ref_w[0] == o_rpt1_bits ##1 !o_rpt1_valid || ref_w[0] != $past(ref_w[0]);
	endproperty
	a_ref: assert property (p_ref) else $error("reference not the reported value");

	// The release edge still shows the reset value, so checking starts one cycle later.
	property p_dir;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_rst_n |=> o_rpt_up == ($past(i_mode) inside {OBF_LT, OBF_LT_RELAY});
	endproperty
	a_dir: assert property (p_dir) else $error("report direction wrong");
endmodule // obf_filter

// ===== pkg/obf_consts.svh
// Constant offsets, reset values and code points of the overhead bit change filter.
`ifndef OBF_CONSTS_SVH
`define OBF_CONSTS_SVH
`define OBF_OFS_CTRL 4'h0
`define OBF_OFS_STATUS 4'h4
`define OBF_OFS_REF 4'h8
`define OBF_OFS_COUNT 4'hC
`define OBF_CTRL_RST 1'h1
`define OBF_CMD_PREFIX 5'h11
`define OBF_CMD_GRP_BIT 2
`define OBF_ST_LINE_ACTIVE 4'h1
`define OBF_ST_PEND_TRANSP 4'h2
`define OBF_ST_ST_DEACT 4'h3
`define OBF_ST_PEND_DEACT 4'h4
`define OBF_ST_TRANSP 4'h5
`define OBF_ST_SYNC1 4'h6
`define OBF_ST_SYNC2 4'h7
`define OBF_ST_WAIT_ACT 4'h8
`define OBF_ST_ERROR 4'h9
`define OBF_ST_PEND_DEACT_ST 4'hA
`define OBF_ST_PEND_DEACT_U 4'hB
`define OBF_ST_ALOOP 4'hC
`endif

// ===== pkg/obf_pkg.sv
// Types shared by the overhead bit change filter.
package obf_pkg;
	typedef enum logic [1:0] {OBF_ON_CHANGE, OBF_CRC, OBF_TRIPLE, OBF_TRIPLE_CRC} obf_meth_e;
	typedef enum logic [1:0] {OBF_LT, OBF_NT, OBF_LT_RELAY, OBF_NT_RELAY} obf_mode_e;
endpackage

// ===== sim/obf_ctl_model.sv
// Controller model that issues local command messages.
`timescale 1ns/100ps
module obf_ctl_model (
	// Clock.
	input wire logic i_sys_clk,
	// Local command message.
	output logic o_lcmd_valid,
	output logic o_lcmd_reg,
	output logic [7:0] o_lcmd_code
);
	initial begin
		o_lcmd_valid = 1'b0;
		o_lcmd_reg = 1'b0;
		o_lcmd_code = 8'h00;
	end
	task automatic send(input logic r, input logic [7:0] code);
		@(posedge i_sys_clk);
		o_lcmd_valid <= 1'b1;
		o_lcmd_reg <= r;
		o_lcmd_code <= code;
		@(posedge i_sys_clk);
		o_lcmd_valid <= 1'b0;
		o_lcmd_code <= ~code;
	endtask
endmodule // obf_ctl_model

// ===== sim/obf_filter_test.sv
// Self-checking bench of the overhead bit change filter.
`timescale 1ns/100ps
module obf_filter_test;
	import obf_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_hsel = 1'b0;
	logic i_hwrite = 1'b0;
	logic [31:0] i_haddr = 32'h0;
	logic [31:0] i_hwdata = 32'h0;
	logic [1:0] i_htrans = 2'h0;
	logic [2:0] i_hsize = 3'h2;
	logic i_sf_valid = 1'b0;
	logic [7:0] i_sf_grp1 = 8'h00;
	logic [2:0] i_sf_grp2 = 3'h0;
	logic i_sf_crc_ok = 1'b0;
	obf_mode_e i_mode = OBF_NT;
	logic [3:0] i_rx_state = 4'h6;
	logic i_test_entry = 1'b0;
	logic lv, lr, o_hreadyout, o_hresp, o_rpt1_valid, o_rpt2_valid, o_rpt_up;
	logic [7:0] lc, o_rpt1_bits, r1 = 0, p1a = 0, p1b = 0;
	logic [2:0] o_rpt2_bits, r2 = 0, p2a = 0, p2b = 0;
	logic [31:0] o_hrdata, q, rnd = 32'd92319;
	logic ca = 0, cb = 0, en = 1;
	obf_meth_e m1 = OBF_TRIPLE, m2 = OBF_TRIPLE;
	int n_mismatch = 0, cmp_count = 0, n_rpt = 0;
	obf_ctl_model i_ctl (.i_sys_clk, .o_lcmd_valid(lv), .o_lcmd_reg(lr), .o_lcmd_code(lc));
	obf_filter i_dut (.i_sys_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
		.i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata, .i_sf_valid,
		.i_sf_grp1, .i_sf_grp2, .i_sf_crc_ok, .i_mode, .i_rx_state, .i_test_entry,
		.i_lcmd_valid(lv), .i_lcmd_reg(lr), .i_lcmd_code(lc), .o_rpt1_valid, .o_rpt1_bits,
		.o_rpt2_valid, .o_rpt2_bits, .o_rpt_up);
	always #5 i_sys_clk = ~i_sys_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic perm(input obf_mode_e m, input logic [3:0] s);
		logic [15:0] k [4] = '{16'h003E, 16'h1FE0, 16'h0034, 16'h1270};
		return k[m][s];
	endfunction
	function automatic logic qual(input obf_meth_e m, input logic [7:0] c, a, b);
		logic t;
		t = (c == a) && (c == b);
		case (m)
			OBF_TRIPLE: return t;
			OBF_CRC: return ca & cb;
			OBF_TRIPLE_CRC: return t & ca & cb;
			default: return 1'b1;
		endcase
	endfunction
	function automatic logic [31:0] stx();
		return {27'h0, perm(i_mode, i_rx_state), m2, m1};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge i_sys_clk);
		i_hsel <= 1'b1;
		i_haddr <= a;
		i_htrans <= 2'h2;
		i_hwrite <= w;
		do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
		i_htrans <= 2'h0;
		i_hsel <= 1'b0;
		i_hwdata <= d;
		do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
		q = o_hrdata;
		chk("hresp", {31'h0, o_hresp}, 32'h0);
	endtask
	task automatic rd(input logic [31:0] a, e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic cmd(input logic r, input logic [7:0] c);
		i_ctl.send(r, c);
		if (!r && c[7:3] == 5'h11) begin
			if (c[2])
				m1 = obf_meth_e'(c[1:0]);
			else
				m2 = obf_meth_e'(c[1:0]);
		end
		rd(32'h4, stx(), "status");
	endtask
	task automatic tent(input obf_mode_e md);
		i_mode <= md;
		@(posedge i_sys_clk);
		i_test_entry <= 1'b1;
		@(posedge i_sys_clk);
		i_test_entry <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		m1 = (md inside {OBF_LT_RELAY, OBF_NT_RELAY}) ? OBF_CRC : OBF_TRIPLE;
		m2 = m1;
		rd(32'h4, stx(), "status");
	endtask
	task automatic sf(input logic [7:0] a, input logic [2:0] b, input logic c);
		logic x1, x2;
		@(posedge i_sys_clk);
		i_sf_valid <= 1'b1;
		i_sf_grp1 <= a;
		i_sf_grp2 <= b;
		i_sf_crc_ok <= c;
		@(posedge i_sys_clk);
		i_sf_valid <= 1'b0;
		i_sf_grp1 <= ~a;
		x1 = en & perm(i_mode, i_rx_state) & (a != r1) & qual(m1, a, p1a, p1b);
		x2 = en & perm(i_mode, i_rx_state) & (b != r2) & qual(m2, {5'h0, b}, {5'h0, p2a}, {5'h0, p2b});
		n_rpt += int'(x1) + int'(x2);
		#1;
		chk("rpt1_valid", o_rpt1_valid, x1);
		chk("rpt2_valid", o_rpt2_valid, x2);
		chk("rpt_up", o_rpt_up, i_mode inside {OBF_LT, OBF_LT_RELAY});
		if (x1) begin
			chk("rpt1_bits", o_rpt1_bits, a);
			r1 = a;
		end
		if (x2) begin
			chk("rpt2_bits", o_rpt2_bits, b);
			r2 = b;
		end
		p1b = p1a;
		p1a = a;
		p2b = p2a;
		p2a = b;
		cb = ca;
		ca = c;
	endtask
	initial begin
		repeat (30000) @(posedge i_sys_clk);
		n_mismatch++;
		test_done();
	end
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		rd(32'h4, stx(), "status");
		rd(32'h0, 32'h1, "ctrl");
		rd(32'h10, 32'h0, "unmapped");
		bus(1'b1, 32'h10, 32'h0);
		rd(32'h0, 32'h1, "ctrl");
		for (int c = 8'h88; c <= 8'h8F; c++) begin
			cmd(1'b0, 8'(c));
			for (int k = 0; k < 9; k++) begin
				if (k % 3 == 0)
					rnd = lfsr(rnd);
				sf(rnd[7:0], rnd[10:8], rnd[12 + k]);
			end
		end
		cmd(1'b1, 8'h8C);
		cmd(1'b0, 8'h9C);
		cmd(1'b0, 8'h8C);
		cmd(1'b0, 8'h88);
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 16; s++) begin
				i_mode <= obf_mode_e'(m);
				i_rx_state <= 4'(s);
				sf(~r1, ~r2, 1'b1);
			end
		i_mode <= OBF_NT;
		i_rx_state <= 4'h6;
		bus(1'b1, 32'h0, 32'h0);
		en = 1'b0;
		sf(~r1, ~r2, 1'b1);
		bus(1'b1, 32'h0, 32'h1);
		en = 1'b1;
		rd(32'h4, stx(), "status");
		tent(OBF_NT_RELAY);
		sf(~r1, ~r2, 1'b0);
		sf(~r1, ~r2, 1'b1);
		sf(~r1, ~r2, 1'b1);
		rd(32'h8, {21'h0, r2, r1}, "ref");
		rd(32'hC, n_rpt, "count");
		bus(1'b1, 32'hC, 32'h0);
		rd(32'hC, 32'h0, "count");
		tent(OBF_NT);
		i_mode <= OBF_LT_RELAY;
		i_rx_state <= 4'h5;
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		{r1, r2, p1a, p1b, p2a, p2b, ca, cb} = 35'h0;
		m1 = OBF_CRC;
		m2 = OBF_CRC;
		repeat (2) @(posedge i_sys_clk);
		rd(32'h4, stx(), "status");
		rd(32'h8, 32'h0, "ref");
		rd(32'hC, 32'h0, "count");
		rd(32'h0, 32'h1, "ctrl");
		repeat (3) sf(8'hA5, 3'h5, 1'b1);
		test_done();
	end
endmodule // obf_filter_test
